/* File: src/frr_cfg.svh */
// Constants of the fastening result reporter: offsets, fields, resets, timing
// Assumes a 100 MHz pclk and an external byte serialiser on the link side
`ifndef FRR_CFG_SVH
`define FRR_CFG_SVH

// --------------------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------------------
`define FRR_OFS_CTRL 12'h000
`define FRR_OFS_STATUS 12'h004
`define FRR_OFS_BUF_IDX 12'h008
`define FRR_OFS_BUF_DATA 12'h00C

// --------------------------------------------------------------------------
// Control fields and reset value
// --------------------------------------------------------------------------
`define FRR_CTRL_TRQ_CTL 0
`define FRR_CTRL_REJ_CLR 1
`define FRR_CTRL_NODATA 2
`define FRR_CTRL_LEN_LSB 8
`define FRR_CTRL_LEN_MSB 14
`define FRR_CTRL_RESET 32'h0000_0000

// --------------------------------------------------------------------------
// Status fields
// --------------------------------------------------------------------------
`define FRR_ST_BUSY 0
`define FRR_ST_OUT_ERR 1
`define FRR_ST_SYS_ERR 2
`define FRR_ST_NAK 3
`define FRR_ST_BLOCKED 4
`define FRR_ST_RETRY_LSB 8
`define FRR_ST_CNT_LSB 16

// --------------------------------------------------------------------------
// Frame buffer entry fields
// --------------------------------------------------------------------------
`define FRR_ENT_MEAS 8
`define FRR_ENT_JUDGE 9
`define FRR_BUF_DEPTH 64
`define FRR_TRQ_FIELD_LEN 7

// --------------------------------------------------------------------------
// Link codes
// --------------------------------------------------------------------------
`define FRR_STX 8'h02
`define FRR_ETX 8'h03
`define FRR_ACK 8'h06
`define FRR_NAK 8'h15
`define FRR_CH_ZERO 8'h30
`define FRR_CH_OK 8'h4F
`define FRR_CH_NG 8'h4E
`define FRR_CH_CNT1 8'h43
`define FRR_CH_ALL 8'h41

// --------------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------------
`define FRR_CLK_KHZ 100000
`define FRR_REPLY_MS 500
`define FRR_REPLY_CYC (`FRR_REPLY_MS * `FRR_CLK_KHZ)
`define FRR_MAX_RETRY 2
`define FRR_ALT_MS 1000
`define FRR_ALT_CYC (`FRR_ALT_MS * `FRR_CLK_KHZ)
`define FRR_POWERUP_CYC 1000

`endif

/* File: src/frr_pkg.sv */
// Types of the fastening result reporter
// Uses no constants from frr_cfg.svh; the state and judge encodings are fixed here
package frr_pkg;

    typedef enum logic [2:0] {
        FRR_IDLE = 3'b000,
        FRR_STX_S = 3'b001,
        FRR_BODY = 3'b010,
        FRR_ETX_S = 3'b011,
        FRR_SUM = 3'b100,
        FRR_WAIT = 3'b101,
        FRR_DONE = 3'b110
    } frr_state_e;

    typedef enum logic [1:0] {
        FRR_J_OK = 2'b00,
        FRR_J_NG = 2'b01,
        FRR_J_CNT1 = 2'b10,
        FRR_J_ALL = 2'b11
    } frr_judge_e;

    typedef struct packed {
        frr_judge_e code;
        logic minus;
    } frr_judge_s;

    typedef struct packed {
        logic ok;
        logic plus_ng;
        logic minus_ng;
        logic green;
        logic red;
        logic show_angle;
        logic sub_show_chan;
        logic disp_active;
    } frr_lamp_s;

endpackage

/* File: src/frr_top.sv */
// Fastening result reporter: frames results, awaits reply, drives indicators
// Assumes an external byte serialiser and host reply decoder on pclk
`timescale 1ns/1ps
`default_nettype none
`include "frr_cfg.svh"

module frr_top #(
    parameter int unsigned REPLY_CYC = `FRR_REPLY_CYC,
    parameter int unsigned ALT_CYC = `FRR_ALT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cycle_done,
    input wire logic measurement_start_torque_reached,
    input wire logic start_trigger,
    input wire logic sys_err_in,
    input wire logic run_reset,
    input wire logic reject_in,
    input wire frr_pkg::frr_judge_s judge,
    input wire logic [7:0] config_switch_bank,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic comp,
    output logic tighten_inhibit,
    output logic data_out_error,
    output logic alarm_lamp,
    output logic sys_error,
    output frr_pkg::frr_lamp_s judgment_lamps
);
    import frr_pkg::*;

    function automatic logic [7:0] frr_body_byte(input logic [9:0] ent,
            input logic zero, input logic [7:0] jch);
        logic [7:0] b;
        b = ent[7:0];
        if (ent[`FRR_ENT_JUDGE]) begin
            b = jch;
        end else if (ent[`FRR_ENT_MEAS] && zero) begin
            b = `FRR_CH_ZERO;
        end
        return b;
    endfunction

    function automatic logic [7:0] frr_sum8(input logic [7:0] a,
            input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0];
    endfunction

    frr_state_e state_q;
    logic [31:0] ctrl_q;
    logic [9:0] frame_mem [0:`FRR_BUF_DEPTH-1];
    logic [5:0] buf_idx_q;
    logic [5:0] idx_q;
    logic [7:0] sum_q;
    logic [31:0] timer_q;
    logic [1:0] retry_q;
    logic nak_q;
    logic start_pend_q;
    logic zero_q;
    logic [7:0] jch_q;
    logic out_err_q;
    logic comm_sys_q;
    logic sys_pend_q;
    logic start_seen_q;
    logic suppress_q;
    logic [15:0] pu_cnt_q;
    logic [15:0] batch_q;
    logic [31:0] alt_cnt_q;
    logic alt_q;
    logic [7:0] cur_byte;
    logic [6:0] frame_len;
    logic tx_take;
    logic apb_go;
    logic reply_ok;
    logic timeout;
    logic exhausted;
    logic [31:0] rd_d;
    logic err_d;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    assign frame_len = ctrl_q[`FRR_CTRL_LEN_MSB:`FRR_CTRL_LEN_LSB];
    assign tx_take = tx_valid && tx_ready;
    assign apb_go = psel && penable && pready;
    assign reply_ok = rx_valid && (rx_data == `FRR_ACK || rx_data == `FRR_NAK);
    assign timeout = (timer_q == REPLY_CYC - 1);
    assign exhausted = timeout && (retry_q == 2'(`FRR_MAX_RETRY));

    // ----------------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------------
    always_comb begin
        rd_d = 32'h0000_0000;
        err_d = 1'b0;
        case (paddr)
            `FRR_OFS_CTRL: rd_d = ctrl_q;
            `FRR_OFS_STATUS: begin
                rd_d[`FRR_ST_BUSY] = (state_q != FRR_IDLE);
                rd_d[`FRR_ST_OUT_ERR] = out_err_q;
                rd_d[`FRR_ST_SYS_ERR] = sys_error;
                rd_d[`FRR_ST_NAK] = nak_q;
                rd_d[`FRR_ST_BLOCKED] = suppress_q;
                rd_d[`FRR_ST_RETRY_LSB +: 2] = retry_q;
                rd_d[`FRR_ST_CNT_LSB +: 16] = batch_q;
            end
            `FRR_OFS_BUF_IDX: rd_d[5:0] = buf_idx_q;
            `FRR_OFS_BUF_DATA: rd_d[9:0] = frame_mem[buf_idx_q];
            default: err_d = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            prdata <= (psel && penable && !pready && !pwrite) ? rd_d : 32'h0000_0000;
            pslverr <= psel && penable && !pready && err_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `FRR_CTRL_RESET;
            buf_idx_q <= 6'h00;
        end else if (apb_go && pwrite) begin
            if (paddr == `FRR_OFS_CTRL) begin
                ctrl_q <= pwdata;
            end
            if (paddr == `FRR_OFS_BUF_IDX) begin
                buf_idx_q <= pwdata[5:0];
            end
            if (paddr == `FRR_OFS_BUF_DATA) begin
                buf_idx_q <= buf_idx_q + 6'h01;
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (apb_go && pwrite && paddr == `FRR_OFS_BUF_DATA) begin
            frame_mem[buf_idx_q] <= pwdata[9:0];
        end
    end

    // ----------------------------------------------------------------------
    // Cycle start, power-up hold-off
    // ----------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pu_cnt_q <= 16'h0000;
            suppress_q <= 1'b0;
        end else begin
            if (pu_cnt_q != 16'(`FRR_POWERUP_CYC)) begin
                pu_cnt_q <= pu_cnt_q + 16'h0001;
            end
            if (sys_err_in && pu_cnt_q != 16'(`FRR_POWERUP_CYC)) begin
                suppress_q <= 1'b1;
            end else if (run_reset) begin
                suppress_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_pend_q <= 1'b0;
        end else if (cycle_done && measurement_start_torque_reached && !suppress_q) begin
            start_pend_q <= 1'b1;
        end else if (state_q == FRR_IDLE) begin
            start_pend_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------------
    // Frame sequencer
    // ----------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= FRR_IDLE;
            idx_q <= 6'h00;
            sum_q <= 8'h00;
            timer_q <= 32'h0000_0000;
            retry_q <= 2'b00;
            nak_q <= 1'b0;
            zero_q <= 1'b0;
            jch_q <= `FRR_CH_OK;
        end else begin
            case (state_q)
                FRR_IDLE: begin
                    if (start_pend_q && !suppress_q) begin
                        state_q <= FRR_STX_S;
                        retry_q <= 2'b00;
                        zero_q <= judge.code == FRR_J_CNT1
                            || judge.code == FRR_J_ALL
                            || (ctrl_q[`FRR_CTRL_NODATA] && sys_pend_q);
                        case (judge.code)
                            FRR_J_OK: jch_q <= `FRR_CH_OK;
                            FRR_J_NG: jch_q <= `FRR_CH_NG;
                            FRR_J_CNT1: jch_q <= `FRR_CH_CNT1;
                            default: jch_q <= `FRR_CH_ALL;
                        endcase
                    end
                end
                FRR_STX_S: begin
                    if (tx_take) begin
                        idx_q <= 6'h00;
                        sum_q <= 8'h00;
                        state_q <= (frame_len == 7'h00) ? FRR_ETX_S : FRR_BODY;
                    end
                end
                FRR_BODY: begin
                    if (tx_take) begin
                        sum_q <= frr_sum8(sum_q, tx_data);
                        if ({1'b0, idx_q} == frame_len - 7'h01) begin
                            state_q <= FRR_ETX_S;
                        end else begin
                            idx_q <= idx_q + 6'h01;
                        end
                    end
                end
                FRR_ETX_S: begin
                    if (tx_take) begin
                        sum_q <= frr_sum8(sum_q, `FRR_ETX);
                        state_q <= FRR_SUM;
                    end
                end
                FRR_SUM: begin
                    if (tx_take) begin
                        timer_q <= 32'h0000_0000;
                        state_q <= FRR_WAIT;
                    end
                end
                FRR_WAIT: begin
                    if (reply_ok) begin
                        nak_q <= (rx_data == `FRR_NAK);
                        state_q <= FRR_DONE;
                    end else if (exhausted) begin
                        state_q <= FRR_DONE;
                    end else if (timeout) begin
                        retry_q <= retry_q + 2'b01;
                        state_q <= FRR_STX_S;
                    end else begin
                        timer_q <= timer_q + 32'h0000_0001;
                    end
                end
                FRR_DONE: state_q <= FRR_IDLE;
                default: state_q <= FRR_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // Byte output
    // ----------------------------------------------------------------------
    always_comb begin
        case (state_q)
            FRR_STX_S: cur_byte = `FRR_STX;
            FRR_BODY: cur_byte = frr_body_byte(frame_mem[idx_q], zero_q,
                jch_q);
            FRR_ETX_S: cur_byte = `FRR_ETX;
            default: cur_byte = sum_q;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
        end else if (tx_take) begin
            tx_valid <= 1'b0;
        end else if (!tx_valid && state_q inside {FRR_STX_S, FRR_BODY,
                FRR_ETX_S, FRR_SUM}) begin
            tx_valid <= 1'b1;
            tx_data <= cur_byte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp <= 1'b0;
            tighten_inhibit <= 1'b0;
        end else begin
            comp <= (state_q == FRR_DONE);
            tighten_inhibit <= (state_q != FRR_IDLE) || start_pend_q;
        end
    end

    // ----------------------------------------------------------------------
    // Errors and batch count
    // ----------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_err_q <= 1'b0;
            comm_sys_q <= 1'b0;
            sys_pend_q <= 1'b0;
            start_seen_q <= 1'b0;
        end else begin
            if (state_q == FRR_WAIT && !reply_ok && exhausted) begin
                if (config_switch_bank[0]) begin
                    comm_sys_q <= 1'b1;
                end else begin
                    out_err_q <= 1'b1;
                end
            end else if (run_reset) begin
                out_err_q <= 1'b0;
                comm_sys_q <= 1'b0;
            end
            if (sys_err_in) begin
                sys_pend_q <= 1'b1;
            end else if (run_reset) begin
                sys_pend_q <= 1'b0;
            end
            if (start_trigger) begin
                start_seen_q <= 1'b1;
            end else if (run_reset) begin
                start_seen_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_out_error <= 1'b0;
            alarm_lamp <= 1'b0;
            sys_error <= 1'b0;
        end else begin
            data_out_error <= out_err_q;
            alarm_lamp <= out_err_q;
            sys_error <= comm_sys_q || (sys_pend_q && start_seen_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            batch_q <= 16'h0000;
        end else if (reject_in && ctrl_q[`FRR_CTRL_REJ_CLR]) begin
            batch_q <= 16'h0000;
        end else if (cycle_done && measurement_start_torque_reached && judge.code == FRR_J_OK)
                begin
            batch_q <= batch_q + 16'h0001;
        end
    end

    // ----------------------------------------------------------------------
    // Judgment indication
    // ----------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_cnt_q <= 32'h0000_0000;
            alt_q <= 1'b0;
        end else if (alt_cnt_q == ALT_CYC - 1) begin
            alt_cnt_q <= 32'h0000_0000;
            alt_q <= !alt_q;
        end else begin
            alt_cnt_q <= alt_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            judgment_lamps <= '0;
        end else begin
            if (measurement_start_torque_reached) begin
                judgment_lamps.disp_active <= 1'b1;
            end else if (run_reset) begin
                judgment_lamps.disp_active <= 1'b0;
            end
            if (cycle_done && measurement_start_torque_reached) begin
                judgment_lamps.ok <= judge.code == FRR_J_OK;
                judgment_lamps.green <= judge.code == FRR_J_OK;
                judgment_lamps.plus_ng <= judge.code == FRR_J_NG
                    && !judge.minus;
                judgment_lamps.minus_ng <= judge.code == FRR_J_NG
                    && judge.minus;
                judgment_lamps.red <= judge.code == FRR_J_NG;
            end
            judgment_lamps.show_angle <= judgment_lamps.ok
                && !ctrl_q[`FRR_CTRL_TRQ_CTL] && alt_q;
            judgment_lamps.sub_show_chan <= judgment_lamps.red && alt_q;
        end
    end

    // ----------------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------------
    a_comp_one_cycle: assert property (comp |=> !comp)
        else $error("completion pulse longer than one cycle");
    a_inhibit_busy: assert property ((state_q != FRR_IDLE) |=> tighten_inhibit)
        else $error("tightening not blocked during exchange");
    a_stx_opens: assert property ((state_q == FRR_IDLE) ##1
            (state_q == FRR_STX_S) ##1 tx_valid |-> tx_data == `FRR_STX)
        else $error("frame does not open with STX");
    a_sum_sent: assert property ((state_q == FRR_SUM && tx_valid)
            |-> tx_data == sum_q)
        else $error("checksum byte wrong");
    a_retry_resend: assert property ((state_q == FRR_WAIT && timeout
            && !reply_ok && !exhausted) |=> state_q == FRR_STX_S)
        else $error("no resend after reply timeout");
    a_fault_raised: assert property ((state_q == FRR_WAIT && exhausted
            && !reply_ok && !config_switch_bank[0]) |=> ##1 data_out_error
            && alarm_lamp)
        else $error("fault not raised after two resends");
    a_reply_ends: assert property ((state_q == FRR_WAIT && reply_ok)
            |=> state_q == FRR_DONE ##1 state_q == FRR_IDLE ##0 comp)
        else $error("reply did not end the exchange");
    a_sys_gated: assert property ((sys_error && !$past(comm_sys_q))
            |-> $past(start_seen_q))
        else $error("system error before start trigger");
    a_count_kept: assert property ((run_reset && !reject_in && !cycle_done)
            |=> batch_q == $past(batch_q))
        else $error("run reset changed batch count");
endmodule // frr_top

`default_nettype wire

/* File: test/frr_host_model.sv */
// Host model: takes frame bytes, checks sum, answers
// Assumes frr_top link side; mode 0 ack, 1 mute, 2 nak
`timescale 1ns/1ps
`default_nettype none
module frr_host_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic [1:0] mode,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid
);
    logic in_q;
    logic etx_q;
    logic [7:0] sum_q;
    logic [7:0] ans_q;
    int dly_q;
    // ----
    // Receive and reply
    // ----
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            in_q <= 1'b0;
            etx_q <= 1'b0;
            sum_q <= 8'h00;
            ans_q <= 8'h00;
            dly_q <= 0;
        end else begin
            tx_ready <= ~tx_ready;
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;
            if (dly_q == 1) begin
                rx_valid <= 1'b1;
                rx_data <= ans_q;
            end
            if (dly_q != 0) dly_q <= dly_q - 1;
            if (tx_valid && tx_ready) begin
                if (!in_q) begin
                    in_q <= (tx_data == 8'h02);
                    sum_q <= 8'h00;
                end else if (!etx_q) begin
                    sum_q <= sum_q + tx_data;
                    etx_q <= (tx_data == 8'h03);
                end else begin
                    in_q <= 1'b0;
                    etx_q <= 1'b0;
                    ans_q <= (tx_data == sum_q && mode != 2) ? 8'h06 : 8'h15;
                    if (mode != 1) dly_q <= 7;
                end
            end
        end
    end
endmodule // frr_host_model
`default_nettype wire

/* File: test/frr_tb_top.sv */
// Bench for frr_top: frames, retries, faults, fill, APB
// Assumes frr_host_model on the link, short reply wait
`timescale 1ns/1ps
`default_nettype none
`include "frr_cfg.svh"
module frr_tb_top;
    import frr_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic cycle_done, measurement_start_torque_reached, start_trigger, sys_err_in;
    logic run_reset, reject_in, tx_valid, tx_ready, rx_valid, comp;
    logic tighten_inhibit, data_out_error, alarm_lamp, sys_error;
    frr_judge_s judge;
    frr_lamp_s judgment_lamps;
    logic [7:0] config_switch_bank, tx_data, rx_data;
    logic [1:0] host_mode;
    logic [7:0] q[$];
    logic [7:0] ex[$];
    int num_errors, total_checks;
    frr_top #(.REPLY_CYC(200), .ALT_CYC(16)) i_frr_top (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cycle_done(cycle_done), .measurement_start_torque_reached(measurement_start_torque_reached),
        .start_trigger(start_trigger), .sys_err_in(sys_err_in),
        .run_reset(run_reset), .reject_in(reject_in), .judge(judge),
        .config_switch_bank(config_switch_bank), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .comp(comp),
        .tighten_inhibit(tighten_inhibit),
        .data_out_error(data_out_error), .alarm_lamp(alarm_lamp),
        .sys_error(sys_error), .judgment_lamps(judgment_lamps));
    frr_host_model i_frr_host_model (.pclk(pclk), .presetn(presetn),
        .tx_data(tx_data), .tx_valid(tx_valid), .mode(host_mode),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));
    always @(posedge pclk) if (tx_valid === 1'b1 && tx_ready === 1'b1)
        q.push_back(tx_data);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ----
    // Shared tasks
    // ----
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 50) num_errors++;
        if (n == 50) give_verdict();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic load(input logic [9:0] en[$], input logic [7:0] bd[$]);
        logic [7:0] s;
        s = 8'h03;
        apb(1, `FRR_OFS_CTRL, 32'(en.size()) << 8);
        apb(1, `FRR_OFS_BUF_IDX, 32'h0000_0000);
        foreach (en[i]) apb(1, `FRR_OFS_BUF_DATA, 32'(en[i]));
        foreach (bd[i]) s += bd[i];
        ex = {8'h02, bd, 8'h03, s};
    endtask
    task automatic run_frame(input frr_judge_e c, input int nfr);
        int n;
        logic seen;
        q.delete();
        seen = 1'b0;
        @(posedge pclk);
        judge <= '{c, 1'b0};
        cycle_done <= 1'b1;
        measurement_start_torque_reached <= 1'b1;
        @(posedge pclk);
        cycle_done <= 1'b0;
        measurement_start_torque_reached <= 1'b0;
        for (n = 0; n < 3000 && comp !== 1'b1; n++) begin
            @(posedge pclk);
            seen |= (tighten_inhibit === 1'b1);
        end
        if (n == 3000) num_errors++;
        if (n == 3000) give_verdict();
        chk(seen, 1);
        chk(q.size(), ex.size() * nfr);
        foreach (q[i]) chk(q[i], ex[i % ex.size()]);
        repeat (4) @(posedge pclk);
    endtask
    task automatic clr();
        run_reset <= 1'b1;
        @(posedge pclk);
        run_reset <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic sc_ack();
        host_mode <= 2'd0;
        load('{10'h041, 10'h042, 10'h043}, '{8'h41, 8'h42, 8'h43});
        run_frame(FRR_J_OK, 1);
        apb(0, `FRR_OFS_STATUS, 0);
        chk(rd[3:0], 4'h0);
    endtask
    task automatic sc_nak();
        host_mode <= 2'd2;
        run_frame(FRR_J_OK, 1);
        apb(0, `FRR_OFS_STATUS, 0);
        chk(rd[3], 1);
    endtask
    task automatic sc_mute();
        logic [15:0] b;
        host_mode <= 2'd1;
        run_frame(FRR_J_OK, 3);
        chk({data_out_error, alarm_lamp, sys_error}, 3'b110);
        apb(0, `FRR_OFS_STATUS, 0);
        b = rd[31:16];
        clr();
        chk({data_out_error, alarm_lamp}, 2'b00);
        apb(0, `FRR_OFS_STATUS, 0);
        chk(rd[31:16], b);
    endtask
    task automatic sc_sys();
        config_switch_bank <= 8'h01;
        host_mode <= 2'd1;
        run_frame(FRR_J_OK, 3);
        chk({data_out_error, sys_error}, 2'b01);
        config_switch_bank <= 8'h00;
        clr();
        chk(sys_error, 0);
    endtask
    task automatic sc_fill();
        host_mode <= 2'd0;
        load('{10'h200, 10'h131}, '{8'h43, 8'h30});
        run_frame(FRR_J_CNT1, 1);
        load('{10'h200, 10'h131}, '{8'h41, 8'h30});
        run_frame(FRR_J_ALL, 1);
        load('{10'h200, 10'h131}, '{8'h4F, 8'h31});
        run_frame(FRR_J_OK, 1);
        chk({judgment_lamps.ok, judgment_lamps.green}, 2'b11);
        load('{10'h200, 10'h131}, '{8'h4E, 8'h31});
        run_frame(FRR_J_NG, 1);
        chk({judgment_lamps.plus_ng, judgment_lamps.red}, 2'b11);
    endtask
    task automatic sc_bad();
        apb(0, 12'h010, 0);
        chk(er, 1);
        chk(rd, 0);
    endtask
    task automatic sc_err();
        sys_err_in <= 1'b1;
        @(posedge pclk);
        sys_err_in <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(sys_error, 0);
        start_trigger <= 1'b1;
        @(posedge pclk);
        start_trigger <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(sys_error, 1);
        clr();
        chk(sys_error, 0);
        apb(1, `FRR_OFS_CTRL, 32'h0000_0002);
        reject_in <= 1'b1;
        @(posedge pclk);
        reject_in <= 1'b0;
        repeat (2) @(posedge pclk);
        apb(0, `FRR_OFS_STATUS, 0);
        chk(rd[31:16], 0);
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, cycle_done, measurement_start_torque_reached} = '0;
        {start_trigger, sys_err_in, run_reset, reject_in} = '0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        judge = '{FRR_J_OK, 1'b0};
        config_switch_bank = 8'h00;
        host_mode = 2'd0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        sc_ack();
        sc_nak();
        sc_mute();
        sc_sys();
        sc_fill();
        sc_bad();
        sc_err();
        give_verdict();
    end
endmodule // frr_tb_top
`default_nettype wire
